// ---- logic/drs_sequencer.sv ----
/*
  Hardware reset sequencer: filters the active-low reset pin, blanks the display,
  loads OTP trim and restores defaults. The pin may be asynchronous to clk_i.
*/
`timescale 1ns/10ps
module drs_sequencer #(
  parameter int SLEEP_CYC = drs_pkg::SLEEP_DONE_CYC,
  parameter int AWAKE_CYC = drs_pkg::AWAKE_DONE_CYC,
  parameter int LOAD_CYC = drs_pkg::LOAD_DONE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hw_reset_in_n_i,
  input wire logic sleeping_i,
  input wire drs_pkg::drs_trim_t otp_trim_i,
  output logic display_blank_o,
  output logic cfg_default_o,
  output logic ready_o,
  output drs_pkg::drs_trim_t trim_o,
  output logic [7:0] cfg_o
);
  logic sync1;
  logic sync2;
  logic [drs_pkg::FILT_W-1:0] low_cnt;
  logic [drs_pkg::FILT_W-1:0] next_low_cnt;
  logic [drs_pkg::FILT_W-1:0] high_cnt;
  logic [drs_pkg::FILT_W-1:0] next_high_cnt;
  logic filt_low;
  logic next_filt_low;
  drs_pkg::drs_state_t state;
  drs_pkg::drs_state_t next_state;
  logic [drs_pkg::TIME_W-1:0] tmr;
  logic [drs_pkg::TIME_W-1:0] next_tmr;
  logic was_awake;
  logic next_was_awake;
  drs_pkg::drs_trim_t trim;
  drs_pkg::drs_trim_t next_trim;
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic blank;
  logic next_blank;

  function automatic logic [drs_pkg::FILT_W-1:0] sat_inc(input logic [drs_pkg::FILT_W-1:0] v);
    sat_inc = (v == drs_pkg::FILT_W'(drs_pkg::FILT_CYC)) ? v : v + 1'b1;
  endfunction

  // Two-stage synchroniser on the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else if (ce_i) begin
      sync1 <= hw_reset_in_n_i;
      sync2 <= sync1;
    end
  end

  // Low and high times are measured; a level flips only when it lasts the threshold.
  always_comb begin
    next_low_cnt = sync2 ? '0 : sat_inc(low_cnt);
    next_high_cnt = sync2 ? sat_inc(high_cnt) : '0;
    next_filt_low = filt_low;
    if (!filt_low && next_low_cnt == drs_pkg::FILT_W'(drs_pkg::FILT_CYC)) begin
      next_filt_low = 1'b1;
    end
    if (filt_low && next_high_cnt == drs_pkg::FILT_W'(drs_pkg::FILT_CYC)) begin
      next_filt_low = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt <= '0;
      high_cnt <= '0;
      filt_low <= 1'b0;
    end else if (ce_i) begin
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
      filt_low <= next_filt_low;
    end
  end

  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_was_awake = was_awake;
    next_trim = trim;
    next_cfg = cfg;
    next_blank = blank;
    case (state)
      drs_pkg::DRS_RUN: begin
        if (filt_low) begin
          next_state = drs_pkg::DRS_HELD;
          next_was_awake = !sleeping_i;
          next_blank = 1'b1;
          next_cfg = drs_pkg::CFG_DEFAULT;
        end
      end
      drs_pkg::DRS_HELD: begin
        next_cfg = drs_pkg::CFG_DEFAULT;
        next_tmr = '0;
        if (!filt_low) begin
          next_state = was_awake ? drs_pkg::DRS_BLANK : drs_pkg::DRS_LOAD;
        end
      end
      drs_pkg::DRS_BLANK: begin
        next_tmr = tmr + 1'b1;
        if (tmr == drs_pkg::TIME_W'(LOAD_CYC - 1)) begin
          next_trim = otp_trim_i;
        end
        if (tmr == drs_pkg::TIME_W'(AWAKE_CYC - 1)) begin
          next_state = drs_pkg::DRS_RUN;
        end
      end
      drs_pkg::DRS_LOAD: begin
        next_tmr = tmr + 1'b1;
        if (tmr == drs_pkg::TIME_W'(LOAD_CYC - 1)) begin
          next_trim = otp_trim_i;
        end
        if (tmr == drs_pkg::TIME_W'(SLEEP_CYC - 1)) begin
          next_state = drs_pkg::DRS_RUN;
        end
      end
      default: begin
        next_state = drs_pkg::DRS_RUN;
      end
    endcase
    if (state != drs_pkg::DRS_HELD && state != drs_pkg::DRS_RUN && filt_low) begin
      next_state = drs_pkg::DRS_HELD;
      next_cfg = drs_pkg::CFG_DEFAULT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= drs_pkg::DRS_RUN;
      tmr <= '0;
      was_awake <= 1'b0;
      trim <= '{drs_pkg::IDENT_RESET, drs_pkg::VOFF_RESET};
      cfg <= drs_pkg::CFG_DEFAULT;
      blank <= 1'b1;
    end else if (ce_i) begin
      state <= next_state;
      tmr <= next_tmr;
      was_awake <= next_was_awake;
      trim <= next_trim;
      cfg <= next_cfg;
      blank <= next_blank;
    end
  end

  assign display_blank_o = blank;
  assign cfg_default_o = (state != drs_pkg::DRS_RUN);
  assign ready_o = (state == drs_pkg::DRS_RUN);
  assign trim_o = trim;
  assign cfg_o = cfg;

  sequence low_long_s;
    (ce_i && !sync2) [*8];
  endsequence

  short_reject_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && sync2 && !filt_low && low_cnt != '0
      && low_cnt < drs_pkg::FILT_W'(drs_pkg::REJECT_CYC)) |=> !filt_low)
    else $error("Short low pulse was accepted.");
  accept_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !filt_low && next_low_cnt == drs_pkg::FILT_W'(drs_pkg::FILT_CYC)) |=> filt_low)
    else $error("Long low pulse not accepted.");
  spike_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (filt_low && high_cnt < drs_pkg::FILT_W'(drs_pkg::REJECT_CYC - 1)) |=> filt_low)
    else $error("High spike ended reset.");
  count_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    low_long_s |-> low_cnt >= drs_pkg::FILT_W'(7))
    else $error("Low counter inconsistent.");
  awake_blank_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == drs_pkg::DRS_BLANK) |-> blank && tmr < drs_pkg::TIME_W'(AWAKE_CYC))
    else $error("Blanking exceeded its limit.");
  sleep_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state == drs_pkg::DRS_HELD && !filt_low && !was_awake)
      |=> state == drs_pkg::DRS_LOAD)
    else $error("Sleep reset ran blanking.");
  defaults_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == drs_pkg::DRS_HELD) |=> cfg == drs_pkg::CFG_DEFAULT)
    else $error("Settings not at defaults.");
  sleep_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == drs_pkg::DRS_LOAD) |-> tmr < drs_pkg::TIME_W'(SLEEP_CYC))
    else $error("Sleep completion too long.");
  awake_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !filt_low && state == drs_pkg::DRS_BLANK
      && tmr == drs_pkg::TIME_W'(AWAKE_CYC - 1)) |=> ready_o)
    else $error("Awake completion missed.");
  otp_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !filt_low && state != drs_pkg::DRS_RUN && state != drs_pkg::DRS_HELD
      && tmr == drs_pkg::TIME_W'(LOAD_CYC - 1)) |=> trim == $past(otp_trim_i))
    else $error("OTP values not latched.");

  // Synchroniser, filter and clock-enable checks.
  sequence high_run_s;
    (ce_i && sync2) [*8];
  endsequence

  sync_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i
      |=> sync1 == $past(hw_reset_in_n_i))
    else $error("Synchroniser first stage lost a sample.");
  sync_second_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i
      |=> sync2 == $past(sync1))
    else $error("Synchroniser second stage lost a sample.");
  sync_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i
      |=> $stable(sync1) && $stable(sync2))
    else $error("Synchroniser moved while disabled.");
  filter_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i
      |=> $stable(low_cnt) && $stable(high_cnt) && $stable(filt_low))
    else $error("Filter moved while disabled.");
  low_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && sync2)
      |=> low_cnt == '0)
    else $error("Low counter not cleared by high level.");
  high_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !sync2)
      |=> high_cnt == '0)
    else $error("High counter not cleared by low level.");
  low_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !sync2 && low_cnt < drs_pkg::FILT_W'(drs_pkg::FILT_CYC))
      |=> low_cnt == $past(low_cnt) + drs_pkg::FILT_W'(1))
    else $error("Low counter did not step.");
  count_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    low_cnt <= drs_pkg::FILT_W'(drs_pkg::FILT_CYC)
      && high_cnt <= drs_pkg::FILT_W'(drs_pkg::FILT_CYC))
    else $error("Filter counter passed its limit.");
  high_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    high_run_s
      |-> high_cnt >= drs_pkg::FILT_W'(7))
    else $error("High counter inconsistent.");
  filt_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!filt_low ##1 filt_low)
      |-> $past(low_cnt) == drs_pkg::FILT_W'(drs_pkg::FILT_CYC - 1))
    else $error("Reset accepted before the threshold.");
  filt_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (filt_low ##1 !filt_low)
      |-> $past(high_cnt) == drs_pkg::FILT_W'(drs_pkg::FILT_CYC - 1))
    else $error("Reset ended before the threshold.");

  // Sequence checks.
  accept_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state == drs_pkg::DRS_RUN && filt_low)
      |=> state == drs_pkg::DRS_HELD && blank)
    else $error("Accepted reset did not blank and hold.");
  capture_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state == drs_pkg::DRS_RUN && filt_low)
      |=> was_awake == !$past(sleeping_i))
    else $error("Sleep state not captured at accept.");
  awake_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state == drs_pkg::DRS_HELD && !filt_low && was_awake)
      |=> state == drs_pkg::DRS_BLANK)
    else $error("Awake reset skipped blanking.");
  held_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state == drs_pkg::DRS_HELD && filt_low)
      |=> state == drs_pkg::DRS_HELD)
    else $error("Hold left while reset still low.");
  held_timer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state == drs_pkg::DRS_HELD)
      |=> tmr == '0)
    else $error("Timer not cleared during hold.");
  restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && filt_low && (state == drs_pkg::DRS_BLANK || state == drs_pkg::DRS_LOAD))
      |=> state == drs_pkg::DRS_HELD && cfg == drs_pkg::CFG_DEFAULT)
    else $error("New reset did not restart the sequence.");
  sleep_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !filt_low && state == drs_pkg::DRS_LOAD && tmr == drs_pkg::TIME_W'(SLEEP_CYC - 1))
      |=> ready_o)
    else $error("Sleep completion missed.");
  blank_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !filt_low && state == drs_pkg::DRS_BLANK && tmr < drs_pkg::TIME_W'(AWAKE_CYC - 1))
      |=> state == drs_pkg::DRS_BLANK && tmr == $past(tmr) + drs_pkg::TIME_W'(1))
    else $error("Blanking ended early.");
  load_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !filt_low && state == drs_pkg::DRS_LOAD && tmr < drs_pkg::TIME_W'(SLEEP_CYC - 1))
      |=> state == drs_pkg::DRS_LOAD && tmr == $past(tmr) + drs_pkg::TIME_W'(1))
    else $error("Sleep sequence ended early.");
  run_trim_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && state == drs_pkg::DRS_RUN)
      |=> $stable(trim))
    else $error("Trim changed outside a reset.");
  state_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i
      |=> $stable(state) && $stable(tmr) && $stable(trim) && $stable(cfg))
    else $error("Sequence moved while disabled.");
  blank_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    blank
      |=> blank)
    else $error("Display left blank state.");
  held_defaults_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state != drs_pkg::DRS_RUN)
      |-> cfg == drs_pkg::CFG_DEFAULT)
    else $error("Settings not default during reset.");
endmodule

// ---- logic/drs_pkg.sv ----
/*
  Constants, types and timing counts for the display reset sequencer.
  Assumes a 100 MHz system clock; all times are converted to cycle counts here.
*/
package drs_pkg;
  localparam int CLK_MHZ = 100;
  localparam int REJECT_US = 5;
  localparam int ACCEPT_US = 10;
  localparam int SLEEP_DONE_MS = 5;
  localparam int AWAKE_DONE_MS = 120;
  localparam int LOAD_DONE_MS = 5;
  localparam int REJECT_CYC = REJECT_US * CLK_MHZ;
  localparam int ACCEPT_CYC = ACCEPT_US * CLK_MHZ;
  // Accept threshold sits between the two bounds.
  localparam int FILT_CYC = (REJECT_CYC + ACCEPT_CYC) / 2;
  // Two synchroniser stages and one state step delay the filtered release.
  localparam int SYNC_LAG = 3;
  localparam int RELEASE_LAG = FILT_CYC + SYNC_LAG;
  // Completion counts start at the filtered release, so that lag is taken off.
  localparam int SLEEP_DONE_CYC = SLEEP_DONE_MS * 1000 * CLK_MHZ - RELEASE_LAG;
  localparam int AWAKE_DONE_CYC = AWAKE_DONE_MS * 1000 * CLK_MHZ - RELEASE_LAG;
  localparam int LOAD_DONE_CYC = LOAD_DONE_MS * 1000 * CLK_MHZ - RELEASE_LAG;
  localparam int FILT_W = 10;
  localparam int TIME_W = 24;
  localparam logic [7:0] IDENT_RESET = 8'h00;
  localparam logic [6:0] VOFF_RESET = 7'h00;
  localparam logic [7:0] CFG_DEFAULT = 8'h00;

  typedef enum logic [1:0] {
    DRS_RUN = 2'b00,
    DRS_HELD = 2'b01,
    DRS_BLANK = 2'b11,
    DRS_LOAD = 2'b10
  } drs_state_t;

  typedef struct packed {
    logic [7:0] module_ident_byte;
    logic [6:0] common_voltage_offset;
  } drs_trim_t;
endpackage

// ---- verification/drs_host_model.sv ----
/*
  Host model that drives the active-low reset pin of the sequencer.
  Assumes the caller stands at a rising edge of clk_i when it calls drive.
*/
`timescale 1ns/10ps
module drs_host_model (
  input wire logic clk_i,
  output logic hw_reset_in_n_o
);
  initial begin
    hw_reset_in_n_o = 1'b1;
  end

  // Sets the pin level, then holds it for the given number of cycles.
  task automatic drive(input logic lvl, input int cyc);
    hw_reset_in_n_o <= lvl;
    repeat (cyc) @(posedge clk_i);
  endtask
endmodule

// ---- verification/display_reset_sequencer_bench.sv ----
/*
  Self-checking bench for the reset sequencer with short completion counts.
  Assumes a 750 cycle filter and the host model in drs_host_model.sv.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module display_reset_sequencer_bench;
  localparam int SLP = 40;
  localparam int AWK = 200;
  localparam int FILT = 750;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sleeping_i = 1'b1;
  logic ce_i = 1'b1;
  drs_pkg::drs_trim_t otp_trim_i = '0;
  logic pin_n;
  logic display_blank_o;
  logic cfg_default_o;
  logic ready_o;
  drs_pkg::drs_trim_t trim_o;
  logic [7:0] cfg_o;
  int fail_count = 0;
  int n_tests = 0;
  int n;
  int seed;

  always #5 clk_i = ~clk_i;

  drs_host_model drs_host_model_i (.clk_i(clk_i), .hw_reset_in_n_o(pin_n));
  drs_sequencer #(.SLEEP_CYC(SLP), .AWAKE_CYC(AWK), .LOAD_CYC(40)) drs_sequencer_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .hw_reset_in_n_i(pin_n),
    .sleeping_i(sleeping_i), .otp_trim_i(otp_trim_i), .display_blank_o(display_blank_o),
    .cfg_default_o(cfg_default_o), .ready_o(ready_o), .trim_o(trim_o), .cfg_o(cfg_o));

  function automatic int done_cyc(input logic slp);
    return slp ? SLP : AWK;
  endfunction

  task automatic final_report();
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wait_ready(input int lim, output int cnt);
    cnt = 0;
    while (ready_o !== 1'b1) begin
      @(posedge clk_i);
      cnt++;
      if (cnt > lim) begin
        fail_count++;
        $display("BAD %0t ready never returned", $time);
        final_report();
      end
    end
  endtask

  task automatic hold_high(input int cyc);
    repeat (cyc) begin
      @(posedge clk_i);
      `CHK(ready_o, 1'b1)
    end
  endtask

  task automatic short_pulse(input int len);
    drs_host_model_i.drive(1'b0, len);
    drs_host_model_i.drive(1'b1, 0);
    hold_high(FILT + 50);
  endtask

  task automatic do_reset(input int low, input logic slp, input drs_pkg::drs_trim_t otp);
    int d;
    d = done_cyc(slp);
    sleeping_i <= slp;
    otp_trim_i <= otp;
    drs_host_model_i.drive(1'b0, low);
    `CHK(ready_o, 1'b0)
    `CHK(cfg_default_o, 1'b1)
    `CHK(display_blank_o, 1'b1)
    drs_host_model_i.drive(1'b1, 0);
    wait_ready(FILT + d + 20, n);
    `CHK(n > FILT + d / 2, 1'b1)
    `CHK(n <= FILT + d + 6, 1'b1)
    `CHK(trim_o, otp)
    `CHK(cfg_o, 8'h00)
    repeat (5) @(posedge clk_i);
  endtask

  initial begin
    seed = $urandom(32'h5C3DC54B);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(ready_o, 1'b1)
    `CHK(trim_o, 15'h0000)
    ce_i <= 1'b0;
    drs_host_model_i.drive(1'b0, FILT + 300);
    `CHK(ready_o, 1'b1)
    ce_i <= 1'b1;
    drs_host_model_i.drive(1'b1, 0);
    hold_high(FILT + 50);
    short_pulse(FILT / 2 + 120);
    do_reset(1100, 1'b1, 15'h5A3C);
    do_reset(1001, 1'b0, 15'h2BC1);
    sleeping_i <= 1'b1;
    drs_host_model_i.drive(1'b0, 1100);
    drs_host_model_i.drive(1'b1, 300);
    `CHK(ready_o, 1'b0)
    drs_host_model_i.drive(1'b0, 600);
    drs_host_model_i.drive(1'b1, 0);
    wait_ready(FILT + SLP + 20, n);
    `CHK(n > FILT + SLP / 2, 1'b1)
    drs_host_model_i.drive(1'b0, $urandom_range(501, 999));
    drs_host_model_i.drive(1'b1, 0);
    repeat (FILT + 10) @(posedge clk_i);
    wait_ready(2000, n);
    repeat (8) begin
      if ($urandom_range(0, 1) == 1) begin
        do_reset($urandom_range(1001, 1600), 1'($urandom_range(0, 1)), 15'($urandom));
      end else begin
        short_pulse($urandom_range(1, 499));
      end
    end
    final_report();
  end
endmodule
